// [tpt_pkg.sv]
// constants, types and register map of the two-channel pwm timer core
package tpt_pkg;
	localparam logic [3:0] ADDR_STATUS     = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h1;
	localparam logic [3:0] ADDR_COUNT_LOW  = 4'h2;
	localparam logic [3:0] ADDR_PERIOD_HI  = 4'h3;
	localparam logic [3:0] ADDR_PERIOD_LO  = 4'h4;
	localparam logic [3:0] ADDR_CH0_CTRL   = 4'h5;
	localparam logic [3:0] ADDR_CH0_CMP_HI = 4'h6;
	localparam logic [3:0] ADDR_CH0_CMP_LO = 4'h7;
	localparam logic [3:0] CH_STRIDE       = 4'h3;

	localparam int STAT_FLAG_BIT  = 7;
	localparam int STAT_IE_BIT    = 6;
	localparam int STAT_HALT_BIT  = 5;
	localparam int STAT_CLEAR_BIT = 4;
	localparam int CH_FLAG_BIT    = 7;
	localparam int CH_LINK_BIT    = 5;

	localparam logic [7:0]  STATUS_RESET = 8'h20;
	localparam logic [7:0]  CHCTRL_RESET = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [2:0]  DIV_EXT      = 3'h7;

	localparam logic [1:0] ELS_NONE   = 2'h0;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_CLEAR  = 2'h2;
	localparam logic [1:0] ELS_SET    = 2'h3;

	typedef struct packed {
		logic       flag;
		logic       irq_en;
		logic       linked;
		logic       func;
		logic [1:0] els;
		logic       wrap;
		logic       full;
	} tpt_chctrl_t;
endpackage : tpt_pkg

// [tpt_channel.sv]
// one timer channel: control register, event flag, capture detect, output level
`timescale 1ns/1ps
module tpt_channel
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 wr_ctrl,
	input  wire logic                 rd_ctrl,
	input  wire logic [7:0]           wdata,
	input  wire logic                 protect,
	input  wire logic                 is_slave,
	input  wire logic                 cmp_match,
	input  wire logic                 ovf_event,
	input  wire logic                 capture_ok,
	input  wire logic                 pin_sync,
	output tpt_pkg::tpt_chctrl_t      ctrl,
	output logic                      capture_pulse,
	output logic                      pin_out,
	output logic                      pin_oe,
	output logic                      irq
);
	import tpt_pkg::*;

	logic armed;
	logic prev_pin;
	logic next_level;

	////////////////////////////////////////////////////////////////
	// mode decode: linked overrides function select
	wire capture_mode = !is_slave && !ctrl.linked && !ctrl.func && ctrl.els != ELS_NONE;
	wire output_mode  = !is_slave && (ctrl.linked || ctrl.func) && ctrl.els != ELS_NONE;
	wire rise         = pin_sync && !prev_pin;
	wire fall         = !pin_sync && prev_pin;
	wire edge_hit     = (ctrl.els[0] && rise) || (ctrl.els[1] && fall);
	assign capture_pulse = capture_mode && capture_ok && edge_hit;
	wire event_hit    = capture_pulse || (output_mode && cmp_match);
	wire clear_ok     = wr_ctrl && !wdata[CH_FLAG_BIT] && armed && !event_hit && !protect;
	// pulse level is the opposite of what a clear or set compare drives; it is low in toggle mode
	wire pulse_level  = ctrl.els == ELS_CLEAR;
	wire cmp_level    = (ctrl.els == ELS_TOGGLE) ? !pin_out : ctrl.els[0];

	// overflow toggle is checked before compare so it wins a tie
	assign next_level = !output_mode ? ((ctrl.els == ELS_NONE) ? !ctrl.func : pin_out)
		: (ctrl.wrap && ctrl.full) ? pulse_level
		: (ctrl.wrap && ovf_event) ? !pin_out
		: cmp_match ? cmp_level
		: pin_out;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl     <= CHCTRL_RESET;
			armed    <= 1'b0;
			prev_pin <= 1'b0;
			pin_out  <= 1'b0;
			pin_oe   <= 1'b0;
			irq      <= 1'b0;
		end
		else
		begin
			prev_pin <= pin_sync;
			pin_out  <= next_level;
			pin_oe   <= output_mode;
			irq      <= ctrl.flag && ctrl.irq_en;
			if (wr_ctrl)
				ctrl[6:0] <= wdata[6:0];
			// set wins over a clear in the same cycle
			if (event_hit)
				ctrl.flag <= 1'b1;
			else if (clear_ok)
				ctrl.flag <= 1'b0;
			if (event_hit)
				armed <= 1'b0;
			else if (rd_ctrl && ctrl.flag && !protect)
				armed <= 1'b1;
			else if (wr_ctrl && !protect)
				armed <= 1'b0;
		end
	end
endmodule : tpt_channel

// [tpt_core.sv]
// two-channel pwm timer core: counter, prescaler, register port, channel pair
`timescale 1ns/1ps
module tpt_core
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata,
	input  wire logic       ext_count_clock,
	input  wire logic       pin_direction_bit,
	output logic            ext_clock_pin_oe,
	input  wire logic       channel0_pin_in,
	output logic            channel0_pin_out,
	output logic            channel0_pin_oe,
	input  wire logic       channel1_pin_in,
	output logic            channel1_pin_out,
	output logic            channel1_pin_oe,
	input  wire logic       wait_mode,
	input  wire logic       stop_mode,
	input  wire logic       break_active,
	input  wire logic       break_clear_allow,
	output logic            ovf_irq,
	output logic [1:0]      ch_irq,
	output logic            wake_request
);
	import tpt_pkg::*;

	function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction : reg_hit

	// bus clock divided by 2^sel: tick when the low sel prescaler bits are all ones
	function automatic logic div_tick(input logic [2:0] sel, input logic [5:0] p);
		logic [5:0] mask;
		mask = 6'((7'h01 << sel) - 7'h01);
		return &(p | ~mask);
	endfunction : div_tick

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       ext_prev;
	wire  [2:0] pins_raw = {ext_count_clock, channel1_pin_in, channel0_pin_in};

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_a   <= 3'h0;
			sync_b   <= 3'h0;
			ext_prev <= 1'b0;
		end
		else
		begin
			sync_a   <= pins_raw;
			sync_b   <= sync_a;
			ext_prev <= sync_b[2];
		end
	end

	////////////////////////////////////////////////////////////////
	// state
	logic        overflow_flag;
	logic        overflow_irq_enable;
	logic        counter_halt;
	logic [2:0]  clock_divider_select;
	logic        ovf_armed;
	logic [5:0]  presc;
	logic [15:0] count;
	logic [15:0] period_limit;
	logic        period_pending;
	logic [7:0]  low_buf;
	logic        low_latched;
	logic [15:0] cmp [2];
	logic        active_sel;
	logic        last_written;
	tpt_chctrl_t ch_ctrl [2];
	logic [1:0]  ch_capture;
	logic [1:0]  ch_pin_out;
	logic [1:0]  ch_pin_oe;
	logic [1:0]  ch_irq_int;
	logic [7:0]  read_value;

	////////////////////////////////////////////////////////////////
	// register port decode; the cpu cannot reach the block in wait mode
	wire wr_en     = wr && !wait_mode;
	wire rd_en     = rd && !wait_mode;
	wire wr_status = wr_en && reg_hit(addr, ADDR_STATUS);
	wire rd_status = rd_en && reg_hit(addr, ADDR_STATUS);
	wire rd_cnt_hi = rd_en && reg_hit(addr, ADDR_COUNT_HIGH);
	wire rd_cnt_lo = rd_en && reg_hit(addr, ADDR_COUNT_LOW);
	wire wr_per_hi = wr_en && reg_hit(addr, ADDR_PERIOD_HI);
	wire wr_per_lo = wr_en && reg_hit(addr, ADDR_PERIOD_LO);
	wire protect   = break_active && !break_clear_allow;
	wire clr_write = wr_status && wdata[STAT_CLEAR_BIT];
	wire linked    = ch_ctrl[0].linked;

	////////////////////////////////////////////////////////////////
	// prescaler and counter
	wire run        = !counter_halt && !stop_mode && !break_active;
	wire ext_rise   = sync_b[2] && !ext_prev;
	wire tick       = run && ((clock_divider_select == DIV_EXT) ? ext_rise
		: div_tick(clock_divider_select, presc));
	wire [15:0] next_count = (count == period_limit) ? 16'h0000 : 16'(count + 16'h0001);
	wire ovf_event  = tick && !clr_write && next_count == period_limit;
	wire ovf_set    = ovf_event && !period_pending;
	wire ovf_clear  = wr_status && !wdata[STAT_FLAG_BIT] && ovf_armed && !ovf_set && !protect;
	wire [15:0] cmp0_live = (linked && active_sel) ? cmp[1] : cmp[0];
	wire [1:0] ch_match;
	assign ch_match[0] = tick && !clr_write && next_count == cmp0_live;
	assign ch_match[1] = tick && !clr_write && next_count == cmp[1];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			presc <= 6'h00;
			count <= 16'h0000;
		end
		else if (clr_write)
		begin
			presc <= 6'h00;
			count <= 16'h0000;
		end
		else
		begin
			if (run)
				presc <= 6'(presc + 6'h01);
			if (tick)
				count <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////
	// status and control register, overflow flag with two-step clear
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			overflow_flag        <= STATUS_RESET[STAT_FLAG_BIT];
			overflow_irq_enable  <= STATUS_RESET[STAT_IE_BIT];
			counter_halt         <= STATUS_RESET[STAT_HALT_BIT];
			clock_divider_select <= STATUS_RESET[2:0];
			ovf_armed            <= 1'b0;
		end
		else
		begin
			if (wr_status)
			begin
				overflow_irq_enable  <= wdata[STAT_IE_BIT];
				counter_halt         <= wdata[STAT_HALT_BIT];
				clock_divider_select <= wdata[2:0];
			end
			if (ovf_set)
				overflow_flag <= 1'b1;
			else if (ovf_clear)
				overflow_flag <= 1'b0;
			if (ovf_set)
				ovf_armed <= 1'b0;
			else if (rd_status && overflow_flag && !protect)
				ovf_armed <= 1'b1;
			else if (wr_status && !protect)
				ovf_armed <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// period limit, counter read latch
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			period_limit   <= PERIOD_RESET;
			period_pending <= 1'b0;
			low_buf        <= 8'h00;
			low_latched    <= 1'b0;
		end
		else
		begin
			if (wr_per_hi)
			begin
				period_limit[15:8] <= wdata;
				period_pending     <= 1'b1;
			end
			if (wr_per_lo)
			begin
				period_limit[7:0] <= wdata;
				period_pending    <= 1'b0;
			end
			if (rd_cnt_hi && !low_latched)
			begin
				low_buf     <= count[7:0];
				low_latched <= 1'b1;
			end
			else if (rd_cnt_lo)
				low_latched <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// channels and their compare registers
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_ch
			localparam logic [3:0] BASE = 4'(ADDR_CH0_CTRL + CH_STRIDE * i);
			wire wr_ctrl = wr_en && reg_hit(addr, BASE);
			wire rd_ctrl = rd_en && reg_hit(addr, BASE);
			wire wr_hi   = wr_en && reg_hit(addr, 4'(BASE + 4'h1));
			wire wr_lo   = wr_en && reg_hit(addr, 4'(BASE + 4'h2));
			// only channel 0 owns the link bit
			wire [7:0] ctrl_wdata = (i == 0) ? wdata : (wdata & ~(8'h01 << CH_LINK_BIT));

			tpt_channel u_channel
			(
				.clk           (clk),
				.rst           (rst),
				.wr_ctrl       (wr_ctrl),
				.rd_ctrl       (rd_ctrl),
				.wdata         (ctrl_wdata),
				.protect       (protect),
				.is_slave      ((i == 1) && linked),
				.cmp_match     (ch_match[i]),
				.ovf_event     (ovf_event),
				.capture_ok    (!counter_halt && !break_active),
				.pin_sync      (sync_b[i]),
				.ctrl          (ch_ctrl[i]),
				.capture_pulse (ch_capture[i]),
				.pin_out       (ch_pin_out[i]),
				.pin_oe        (ch_pin_oe[i]),
				.irq           (ch_irq_int[i])
			);

			always_ff @(posedge clk)
			begin
				if (ch_capture[i])
					cmp[i] <= count;
				else if (wr_hi)
					cmp[i][15:8] <= wdata;
				else if (wr_lo)
					cmp[i][7:0] <= wdata;
			end
		end
	endgenerate

	// buffered pair: the member written last takes over at overflow
	wire cmp_written_0 = wr_en && (reg_hit(addr, ADDR_CH0_CMP_HI) || reg_hit(addr, ADDR_CH0_CMP_LO));
	wire cmp_written_1 = wr_en && (reg_hit(addr, 4'(ADDR_CH0_CMP_HI + CH_STRIDE))
		|| reg_hit(addr, 4'(ADDR_CH0_CMP_LO + CH_STRIDE)));

	always_ff @(posedge clk)
	begin
		if (rst || !linked)
		begin
			active_sel   <= 1'b0;
			last_written <= 1'b0;
		end
		else
		begin
			if (cmp_written_1)
				last_written <= 1'b1;
			else if (cmp_written_0)
				last_written <= 1'b0;
			if (ovf_event)
				active_sel <= last_written;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux, unmapped addresses read zero
	wire [7:0] status_read = {overflow_flag, overflow_irq_enable, counter_halt, 2'b00, clock_divider_select};
	wire [7:0] cnt_lo_read = low_latched ? low_buf : count[7:0];

	always_comb
	begin
		read_value = 8'h00;
		case (addr)
			ADDR_STATUS:                            read_value = status_read;
			ADDR_COUNT_HIGH:                        read_value = count[15:8];
			ADDR_COUNT_LOW:                         read_value = cnt_lo_read;
			ADDR_PERIOD_HI:                         read_value = period_limit[15:8];
			ADDR_PERIOD_LO:                         read_value = period_limit[7:0];
			ADDR_CH0_CTRL:                          read_value = ch_ctrl[0];
			ADDR_CH0_CMP_HI:                        read_value = cmp[0][15:8];
			ADDR_CH0_CMP_LO:                        read_value = cmp[0][7:0];
			4'(ADDR_CH0_CTRL + CH_STRIDE):          read_value = ch_ctrl[1];
			4'(ADDR_CH0_CMP_HI + CH_STRIDE):        read_value = cmp[1][15:8];
			4'(ADDR_CH0_CMP_LO + CH_STRIDE):        read_value = cmp[1][7:0];
			default:                                read_value = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata            <= 8'h00;
			ext_clock_pin_oe <= 1'b0;
			ovf_irq          <= 1'b0;
			wake_request     <= 1'b0;
			channel0_pin_out <= 1'b0;
			channel0_pin_oe  <= 1'b0;
			channel1_pin_out <= 1'b0;
			channel1_pin_oe  <= 1'b0;
			ch_irq           <= 2'h0;
		end
		else
		begin
			rdata            <= rd_en ? read_value : 8'h00;
			ext_clock_pin_oe <= pin_direction_bit && clock_divider_select != DIV_EXT;
			ovf_irq          <= overflow_flag && overflow_irq_enable;
			wake_request     <= (overflow_flag && overflow_irq_enable) || (|ch_irq_int);
			channel0_pin_out <= ch_pin_out[0];
			channel0_pin_oe  <= ch_pin_oe[0];
			channel1_pin_out <= ch_pin_out[1];
			channel1_pin_oe  <= ch_pin_oe[1];
			ch_irq           <= ch_irq_int;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_arm;
		rd_status && overflow_flag && !protect && !ovf_set;
	endsequence
	sequence s_zero_write;
		wr_status && !wdata[STAT_FLAG_BIT] && !ovf_set && !protect;
	endsequence

	property p_two_step_clear;
		s_arm ##1 s_zero_write |=> !overflow_flag;
	endproperty
	a_two_step_clear: assert property (p_two_step_clear) else $error("flag not cleared by two-step");

	property p_one_write_keeps;
		overflow_flag && wr_status && wdata[STAT_FLAG_BIT] |=> overflow_flag;
	endproperty
	a_one_write_keeps: assert property (p_one_write_keeps) else $error("writing one cleared flag");

	property p_ovf_sets;
		ovf_event && !period_pending |=> overflow_flag;
	endproperty
	a_ovf_sets: assert property (p_ovf_sets) else $error("overflow did not set flag");

	property p_pending_blocks;
		!overflow_flag && ovf_event && period_pending |=> !overflow_flag;
	endproperty
	a_pending_blocks: assert property (p_pending_blocks) else $error("overflow not held off");

	property p_irq_follows;
		overflow_flag && overflow_irq_enable ##1 overflow_flag && overflow_irq_enable |-> ovf_irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

	property p_halt_freezes;
		(counter_halt || break_active || stop_mode) && !clr_write |=> count == $past(count);
	endproperty
	a_halt_freezes: assert property (p_halt_freezes) else $error("counter moved while stopped");

	property p_clear_zero;
		clr_write |=> count == 16'h0000 && presc == 6'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero counter");

	property p_wrap;
		tick && !clr_write && count == period_limit |=> count == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not restart");

	property p_no_capture_halted;
		counter_halt || break_active |-> ch_capture == 2'h0;
	endproperty
	a_no_capture_halted: assert property (p_no_capture_halted) else $error("capture while stopped");
endmodule : tpt_core

// [tpt_pins.sv]
// far-side pin model: external count clock and channel input level
`timescale 1ns/1ps
module tpt_pins
(
	input  wire logic clk,
	output logic      ext_clk,
	output logic      ch_lvl
);
	initial
	begin
		ext_clk = 1'b0;
		ch_lvl  = 1'b0;
	end

	// clock parked low between bursts; hold of 2+ cycles keeps it under half the bus rate
	task automatic pulses(input int n, input int hold);
		for (int i = 0; i < n; i++)
		begin
			repeat (hold) @(posedge clk);
			ext_clk <= 1'b1;
			repeat (hold) @(posedge clk);
			ext_clk <= 1'b0;
		end
	endtask : pulses

	task automatic set_level(input logic v);
		@(posedge clk);
		ch_lvl <= v;
	endtask : set_level
endmodule : tpt_pins

// [two_channel_pwm_timer_core_tb.sv]
// self-checking bench of the two-channel pwm timer core
`timescale 1ns/1ps
module two_channel_pwm_timer_core_tb;
	import tpt_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        dir_bit = 1'b1;
	logic        wait_m = 1'b0;
	logic        stop_m = 1'b0;
	logic        brk = 1'b0;
	logic        allow = 1'b0;
	logic [7:0]  rdata;
	logic        ext_clk, lvl, ext_oe, c0_out, c0_oe, c1_out, c1_oe, ovf_irq, wake;
	logic [1:0]  ch_irq;
	logic [7:0]  b;
	logic [15:0] v, v2, hc;
	int          err_count = 0;
	int          samples_checked = 0;
	int          n, p, s;

	always #2.5 clk = ~clk;

	tpt_pins pins_u (.clk(clk), .ext_clk(ext_clk), .ch_lvl(lvl));

	tpt_core dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_count_clock(ext_clk), .pin_direction_bit(dir_bit), .ext_clock_pin_oe(ext_oe),
		.channel0_pin_in(c0_oe ? c0_out : lvl), .channel0_pin_out(c0_out), .channel0_pin_oe(c0_oe),
		.channel1_pin_in(c1_oe ? c1_out : lvl), .channel1_pin_out(c1_out), .channel1_pin_oe(c1_oe),
		.wait_mode(wait_m), .stop_mode(stop_m), .break_active(brk), .break_clear_allow(allow),
		.ovf_irq(ovf_irq), .ch_irq(ch_irq), .wake_request(wake));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk_eq(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_eq

	task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		samples_checked++;
		if ((^got === 1'bx) || got < lo || got > hi)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	// high first so the low byte comes from the latch
	task automatic rd16(output logic [15:0] d);
		rd_reg(ADDR_COUNT_HIGH, d[15:8]);
		rd_reg(ADDR_COUNT_LOW, d[7:0]);
	endtask : rd16

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// expected high-cycle window of a 4-period pwm sample, lo in upper half
	function automatic logic [31:0] pwm_exp(input int k, input int per);
		int w;
		w = 4 * (per + 1);
		if (k == 0)
			return 32'h0;
		if (k == 1)
			return {16'(w), 16'(w)};
		return {16'(4 * (per / 2 + 1) - 8), 16'(4 * (per / 2 + 1) + 8)};
	endfunction : pwm_exp

	initial
	begin
		#200000;
		err_count++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [7:0] pwm_ctrl [4];
		pwm_ctrl = '{8'h18, 8'h1b, 8'h1a, 8'h2a};
		n = $urandom(32'hf7f842e7);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, STATUS_RESET);
		rd_reg(ADDR_PERIOD_HI, b);
		chk_eq(b, 16'h00ff);
		repeat (20) @(posedge clk);
		rd16(v);
		chk_eq(v, 16'h0);
		wr_reg(ADDR_STATUS, 8'h30);
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h0020);
		rd16(v);
		chk_eq(v, 16'h0);
		for (s = 0; s < 7; s++)
		begin
			n = $urandom_range(319, 64);
			wr_reg(ADDR_STATUS, 8'h30 | 8'(s));
			wr_reg(ADDR_STATUS, 8'(s));
			repeat (n) @(posedge clk);
			wr_reg(ADDR_STATUS, 8'h20 | 8'(s));
			rd16(v);
			chk_rng(v, 16'(n >> s), 16'(((n + 8) >> s) + 1));
		end
		wr_reg(ADDR_STATUS, 8'h30);
		wr_reg(ADDR_STATUS, {5'h0, DIV_EXT});
		settle();
		chk_eq(ext_oe, 1'b0);
		n = $urandom_range(12, 3);
		pins_u.pulses(n, $urandom_range(4, 2));
		repeat (6) @(posedge clk);
		wr_reg(ADDR_STATUS, 8'h27);
		rd16(v);
		chk_eq(v, 16'(n));
		wr_reg(ADDR_STATUS, 8'h30);
		settle();
		chk_eq(ext_oe, 1'b1);
		// overflow, flag clearing, break protection
		p = $urandom_range(40, 8);
		wr_reg(ADDR_PERIOD_HI, 8'h00);
		wr_reg(ADDR_PERIOD_LO, 8'(p));
		wr_reg(ADDR_STATUS, 8'h40);
		for (n = 0; n < 200 && ovf_irq !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk_rng(n, 16'(p - 2), 16'(p + 4));
		if (n == 200)
			give_verdict();
		#1;
		chk_eq(wake, 1'b1);
		wr_reg(ADDR_STATUS, 8'h60);
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h00e0);
		wr_reg(ADDR_STATUS, 8'he0);
		wr_reg(ADDR_STATUS, 8'h60);
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h00e0);
		brk <= 1'b1;
		rd_reg(ADDR_STATUS, b);
		wr_reg(ADDR_STATUS, 8'h60);
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h00e0);
		allow <= 1'b1;
		rd_reg(ADDR_STATUS, b);
		wr_reg(ADDR_STATUS, 8'h60);
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h0060);
		settle();
		chk_eq(ovf_irq, 1'b0);
		brk <= 1'b0;
		wait_m <= 1'b1;
		rd_reg(ADDR_STATUS, b);
		chk_eq(b, 16'h0);
		wait_m <= 1'b0;
		// freeze under stop and break
		wr_reg(ADDR_STATUS, 8'h30);
		wr_reg(ADDR_STATUS, 8'h00);
		for (s = 0; s < 2; s++)
		begin
			stop_m <= (s == 0);
			brk    <= (s == 1);
			settle();
			rd16(v);
			chk_rng(v, 16'h0, 16'(p));
			repeat (30) @(posedge clk);
			rd16(v2);
			chk_eq(v2, v);
		end
		// released once here so no signal gets two assignments in one step
		stop_m <= 1'b0;
		brk    <= 1'b0;
		// pwm start sequence: 0 %, 100 %, half, linked pair
		p = 2 * $urandom_range(15, 4);
		for (s = 0; s < 4; s++)
		begin
			wr_reg(ADDR_STATUS, 8'h30);
			wr_reg(ADDR_PERIOD_HI, 8'h00);
			wr_reg(ADDR_PERIOD_LO, 8'(p));
			wr_reg(ADDR_CH0_CMP_HI, 8'h00);
			wr_reg(ADDR_CH0_CMP_LO, 8'(p / 2));
			wr_reg(ADDR_CH0_CTRL, pwm_ctrl[s]);
			wr_reg(ADDR_STATUS, 8'h00);
			repeat (2 * (p + 1)) @(posedge clk);
			hc = 16'h0;
			for (int i = 0; i < 4 * (p + 1); i++)
			begin
				@(posedge clk);
				#1;
				hc = hc + 16'(c0_out);
			end
			chk_rng(hc, pwm_exp(s, p) >> 16, 16'(pwm_exp(s, p)));
			chk_eq(c0_oe, 1'b1);
		end
		wr_reg(ADDR_STATUS, 8'h30);
		wr_reg(ADDR_CH0_CTRL, 8'h00);
		// capture on channel 1, held off while halted
		wr_reg(ADDR_CH0_CTRL + CH_STRIDE, 8'h44);
		pins_u.set_level(1'b1);
		repeat (8) @(posedge clk);
		rd_reg(ADDR_CH0_CTRL + CH_STRIDE, b);
		chk_eq(b, 16'h0044);
		pins_u.set_level(1'b0);
		wr_reg(ADDR_STATUS, 8'h00);
		pins_u.set_level(1'b1);
		repeat (8) @(posedge clk);
		rd_reg(ADDR_CH0_CTRL + CH_STRIDE, b);
		chk_eq(b, 16'h00c4);
		settle();
		chk_eq(ch_irq, 2'b10);
		chk_eq({c0_oe, c1_oe}, 2'b00);
		give_verdict();
	end
endmodule : two_channel_pwm_timer_core_tb
